// >>> tcs_consts.svh
/*
  Constants of the timer set: register offsets, control field positions,
  write masks, reset values and prescaler limits.
  Assumes it is included by bare name; definitions only.
*/
`ifndef TCS_CONSTS_SVH
`define TCS_CONSTS_SVH

// ==========================================================
// Bus geometry
`define TCS_ADDR_W        6
`define TCS_DATA_W        16

// ==========================================================
// Register offsets (word addresses)
`define TCS_ADDR_SA_CTRL  6'h00
`define TCS_ADDR_SA_PER   6'h01
`define TCS_ADDR_SA_CNT   6'h02
`define TCS_PAIR_FIRST    3'h1
`define TCS_PAIR_LAST     3'h4
`define TCS_PAIR_SUB_MAX  3'h5
`define TCS_SUB_CTRL      2'h0
`define TCS_SUB_PER       2'h1
`define TCS_SUB_CNT       2'h2

// ==========================================================
// Control word field positions
`define TCS_BIT_RUN       15
`define TCS_BIT_IDLE      13
`define TCS_BIT_GATE      6
`define TCS_BIT_PS_HI     5
`define TCS_BIT_PS_LO     4
`define TCS_BIT_WIDE      3
`define TCS_BIT_SYNC      2
`define TCS_BIT_CS        1

// ==========================================================
// Implemented bits per control register kind
`define TCS_MASK_SA       16'hA076
`define TCS_MASK_EVEN     16'hA07A
`define TCS_MASK_ODD      16'hA072

// ==========================================================
// Reset values and prescaler terminal counts
`define TCS_RST_WORD      16'h0000
`define TCS_PS_LIM_1      8'h00
`define TCS_PS_LIM_8      8'h07
`define TCS_PS_LIM_64     8'h3F
`define TCS_PS_LIM_256    8'hFF

`endif

// >>> tcs_pkg.sv
/*
  Types shared by the timer set modules.
  Assumes tcs_consts.svh is on the include path.
*/
`include "tcs_consts.svh"

package tcs_pkg;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic                      wr;
    logic                      rd;
    logic [`TCS_ADDR_W-1:0]    addr;
    logic [`TCS_DATA_W-1:0]    wdata;
  } tcs_bus_t;

  typedef struct packed {
    logic       run;
    logic       idle_stop;
    logic       gate_accumulate;
    logic [1:0] prescale_select;
    logic       pair_wide_mode;
    logic       ext_clock_sync;
    logic       clock_source_select;
  } tcs_ctrl_t;

  typedef enum logic [1:0] {TCS_K_NONE, TCS_K_CTRL, TCS_K_PER, TCS_K_CNT} tcs_kind_t;

  typedef struct packed {
    tcs_kind_t  kind;
    logic [3:0] idx;
  } tcs_hit_t;

  // ==========================================================
  // Module state
  typedef struct packed {
    logic [7:0] cnt;
  } tcs_ps_st_t;

  typedef struct packed {
    logic [1:0][`TCS_DATA_W-1:0] cnt;
    logic [1:0]                  flag;
  } tcs_pair_st_t;

  typedef struct packed {
    logic [8:0][`TCS_DATA_W-1:0] ctrl;
    logic [8:0][`TCS_DATA_W-1:0] period;
    logic [`TCS_DATA_W-1:0]      sa_count;
    logic                        sa_flag;
    logic [8:0]                  pin_s1;
    logic [8:0]                  pin_s2;
    logic [8:0]                  pin_d;
    logic [`TCS_DATA_W-1:0]      rd_data;
  } tcs_top_st_t;

endpackage : tcs_pkg

// >>> tcs_prescale.sv
/*
  Input clock prescaler: passes one of every 1, 8, 64 or 256 input ticks.
  Assumes tick_in is a one-cycle qualifier on the same clock.
*/
`timescale 1ns/10ps
`include "tcs_consts.svh"

module tcs_prescale (
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       clr_in,
  input  wire logic [1:0] sel_in,
  input  wire logic       tick_in,
  output logic            tick_out
);

  tcs_pkg::tcs_ps_st_t st_ff;
  tcs_pkg::tcs_ps_st_t nxt_st;
  logic [7:0]          lim;

  always_comb begin
    case (sel_in)
      2'h0:    lim = `TCS_PS_LIM_1;
      2'h1:    lim = `TCS_PS_LIM_8;
      2'h2:    lim = `TCS_PS_LIM_64;
      default: lim = `TCS_PS_LIM_256;
    endcase
  end

  assign tick_out = tick_in && (st_ff.cnt == lim); // see RL6

  always_comb begin
    nxt_st = st_ff;
    if (clr_in) begin
      nxt_st.cnt = 8'h00;
    end else if (tick_in) begin
      nxt_st.cnt = (st_ff.cnt == lim) ? 8'h00 : st_ff.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : tcs_prescale

// >>> tcs_pair.sv
/*
  One timer pair: two 16-bit period counters, or one 32-bit counter
  clocked by the even timer when wide mode is set.
  Assumes ticks and gate falls are already qualified by run state.
*/
`timescale 1ns/10ps
`include "tcs_consts.svh"

module tcs_pair (
  input  wire logic                              clk_in,
  input  wire logic                              rst_b_in,
  input  wire logic                              wide_in,
  input  wire logic [1:0]                        tick_in,
  input  wire logic [1:0]                        gate_fall_in,
  input  wire logic [1:0][`TCS_DATA_W-1:0]       period_in,
  output logic      [1:0][`TCS_DATA_W-1:0]       count_out,
  output logic      [1:0]                        flag_out
);

  tcs_pkg::tcs_pair_st_t st_ff;
  tcs_pkg::tcs_pair_st_t nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.flag = 2'h0;
    if (wide_in) begin
      // Odd word is upper half of count and period, flag goes to odd timer
      if (tick_in[0]) begin
        if ({st_ff.cnt[1], st_ff.cnt[0]} == {period_in[1], period_in[0]}) begin // see RL14
          nxt_st.cnt     = '0;
          nxt_st.flag[1] = 1'b1; // see RL13
        end else begin
          nxt_st.cnt = {st_ff.cnt[1], st_ff.cnt[0]} + 32'h0000_0001; // see RL11
        end
      end
      if (gate_fall_in[0]) begin
        nxt_st.flag[1] = 1'b1;
      end
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (tick_in[k]) begin
          if (st_ff.cnt[k] == period_in[k]) begin // see RL21
            nxt_st.cnt[k]  = '0;
            nxt_st.flag[k] = 1'b1;
          end else begin
            nxt_st.cnt[k] = st_ff.cnt[k] + 16'h0001;
          end
        end
        if (gate_fall_in[k]) begin
          nxt_st.flag[k] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign count_out = st_ff.cnt;
  assign flag_out  = st_ff.flag;

endmodule : tcs_pair

// >>> tcs_timer_set.sv
/*
  Timer set top: standalone 16-bit timer, four joinable timer pairs,
  register port, pin synchronisers and trigger outputs.
  Assumes a single 50 MHz clock; idle and sleep levels come from logic on
  the same clock; timer pins are asynchronous and are synchronised here.
*/
// Design decisions made here: the plain strobed port and the register offsets.
// What this block does
// RL1: Standalone 16-bit timer, sync or async counter
// RL2: Standalone flag on period match or gate fall
// RL3: Run bit 15 starts and stops timer
// RL4: Idle-stop bit 13 halts timer in Idle
// RL5: Gate bit 6 only with internal clock
// RL6: Prescale bits 5-4 give 1, 8, 64, 256
// RL7: Sync bit 2 selects external clock synchronisation
// RL8: Source bit 1 picks pin edges or internal
// RL9: Unimplemented control bits read as zero
// RL10: Pairs run 16-bit or 32-bit, never async
// RL11: Odd timer holds upper count word
// RL12: Wide mode uses only even timer controls
// RL13: Wide period match flags the odd timer
// RL14: Odd period is upper word of period
// RL15: Even timer mode bit joins the pair
// RL16: Pairs one and two trigger ADCs
// RL17: Only second and third timers feed capture
// RL18: Only second and third timers trigger DMA
// RL19: Timers may run in Idle and Sleep; in Sleep only the standalone timer runs, on an unsynchronised pin clock
// RL20: Pair mode bit sits at bit 3
// RL21: Count increments, wraps at period, sets flag
// RL22: Gated count advances only while gate high
`timescale 1ns/10ps
`include "tcs_consts.svh"

module tcs_timer_set (
  input  wire logic                        core_clk_in,
  input  wire logic                        rst_b_in,
  input  wire tcs_pkg::tcs_bus_t           bus_in,
  input  wire logic                        idle_in,
  input  wire logic                        sleep_in,
  input  wire logic                        standalone_ext_clock_pin_in,
  input  wire logic [7:0]                  pair_ext_clock_pin_in,
  output logic      [`TCS_DATA_W-1:0]      rd_data_out,
  output logic                             standalone_flag_out,
  output logic      [7:0]                  pair_flag_out,
  output logic      [1:0]                  adc_trig_out,
  output logic      [1:0]                  dma_trig_out,
  output logic      [1:0][`TCS_DATA_W-1:0] capture_base_out
);

  // ==========================================================
  // Helpers
  function automatic tcs_pkg::tcs_ctrl_t tcs_fields(input logic [`TCS_DATA_W-1:0] w);
    tcs_pkg::tcs_ctrl_t c;
    c.run                 = w[`TCS_BIT_RUN];
    c.idle_stop           = w[`TCS_BIT_IDLE];
    c.gate_accumulate     = w[`TCS_BIT_GATE];
    c.prescale_select     = w[`TCS_BIT_PS_HI:`TCS_BIT_PS_LO];
    c.pair_wide_mode      = w[`TCS_BIT_WIDE]; // see RL20
    c.ext_clock_sync      = w[`TCS_BIT_SYNC];
    c.clock_source_select = w[`TCS_BIT_CS];
    return c;
  endfunction : tcs_fields

  // Sleep stops the instruction clock, so only an unsynchronised
  // external count may continue there
  function automatic logic tcs_may_run(input tcs_pkg::tcs_ctrl_t c, input logic idle,
                                       input logic sleep, input logic allow_async);
    logic async_ext;
    async_ext = allow_async && c.clock_source_select && !c.ext_clock_sync; // see RL7
    return c.run && !(idle && c.idle_stop) && !(sleep && !async_ext); // see RL3 see RL4 see RL19
  endfunction : tcs_may_run

  function automatic tcs_pkg::tcs_hit_t tcs_decode(input logic [`TCS_ADDR_W-1:0] a);
    tcs_pkg::tcs_hit_t h;
    h.kind = tcs_pkg::TCS_K_NONE;
    h.idx  = 4'h0;
    if (a == `TCS_ADDR_SA_CTRL) begin
      h.kind = tcs_pkg::TCS_K_CTRL;
    end else if (a == `TCS_ADDR_SA_PER) begin
      h.kind = tcs_pkg::TCS_K_PER;
    end else if (a == `TCS_ADDR_SA_CNT) begin
      h.kind = tcs_pkg::TCS_K_CNT;
    end else if (a[5:3] >= `TCS_PAIR_FIRST && a[5:3] <= `TCS_PAIR_LAST && a[2:0] <= `TCS_PAIR_SUB_MAX) begin
      case (a[2:1])
        `TCS_SUB_CTRL: h.kind = tcs_pkg::TCS_K_CTRL;
        `TCS_SUB_PER:  h.kind = tcs_pkg::TCS_K_PER;
        default:       h.kind = tcs_pkg::TCS_K_CNT;
      endcase
      h.idx = {(a[5:3] - `TCS_PAIR_FIRST), 1'b1} + {3'h0, a[0]};
    end
    return h;
  endfunction : tcs_decode

  function automatic logic [`TCS_DATA_W-1:0] tcs_wmask(input logic [3:0] idx);
    if (idx == 4'h0) begin
      return `TCS_MASK_SA;
    end else if (idx[0]) begin
      return `TCS_MASK_EVEN;
    end
    return `TCS_MASK_ODD; // see RL9
  endfunction : tcs_wmask

  // ==========================================================
  // Reset release
  logic [1:0] rst_sync_ff;
  logic       rst_b_q;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_b_q = rst_sync_ff[1];

  // ==========================================================
  // State
  tcs_pkg::tcs_top_st_t              st_ff;
  tcs_pkg::tcs_top_st_t              nxt_st;
  tcs_pkg::tcs_hit_t                 hit;
  tcs_pkg::tcs_ctrl_t                sa_cfg;
  logic [8:0]                        pin_rise;
  logic [8:0]                        pin_fall;
  logic                              sa_run;
  logic                              sa_gate_on;
  logic                              sa_raw;
  logic                              sa_tick;
  logic                              sa_gate_fall;
  logic [7:0]                        tmr_tick;
  logic [7:0]                        tmr_gfall;
  logic [3:0]                        pair_wide;
  logic [3:0][1:0][`TCS_DATA_W-1:0]  pair_cnt;
  logic [8:0][`TCS_DATA_W-1:0]       cnt_all;

  assign hit      = tcs_decode(bus_in.addr);
  assign pin_rise = st_ff.pin_s2 & ~st_ff.pin_d;
  assign pin_fall = ~st_ff.pin_s2 & st_ff.pin_d;

  // ==========================================================
  // Standalone timer
  assign sa_cfg       = tcs_fields(st_ff.ctrl[0]);
  assign sa_run       = tcs_may_run(sa_cfg, idle_in, sleep_in, 1'b1); // see RL1
  assign sa_gate_on   = sa_cfg.gate_accumulate && !sa_cfg.clock_source_select; // see RL5
  // External edges count on rising pin edges; gated mode counts while high
  assign sa_raw       = sa_run && (sa_cfg.clock_source_select ? pin_rise[0] // see RL8
                                   : (!sa_gate_on || st_ff.pin_s2[0])); // see RL22
  assign sa_gate_fall = sa_run && sa_gate_on && pin_fall[0]; // see RL2

  tcs_prescale u_sa_ps (
    .clk_in   (core_clk_in),
    .rst_b_in (rst_b_q),
    .clr_in   (!sa_run),
    .sel_in   (sa_cfg.prescale_select),
    .tick_in  (sa_raw),
    .tick_out (sa_tick)
  );

  // ==========================================================
  // Paired timers
  genvar j;
  genvar p;
  generate
    for (j = 0; j < 8; j++) begin : g_tmr
      localparam int SELF = j + 1;
      localparam int EVEN = j - (j % 2) + 1;
      tcs_pkg::tcs_ctrl_t cfg;
      logic               wide_hi;
      logic               run;
      logic               gate_on;
      logic               lvl;
      logic               rise;
      logic               fall;
      logic               raw;

      // In wide mode the odd timer takes setup and pin from the even timer
      assign wide_hi = (j % 2 == 1) && st_ff.ctrl[EVEN][`TCS_BIT_WIDE];
      assign cfg     = wide_hi ? tcs_fields(st_ff.ctrl[EVEN]) : tcs_fields(st_ff.ctrl[SELF]); // see RL12
      assign lvl     = wide_hi ? st_ff.pin_s2[EVEN] : st_ff.pin_s2[SELF];
      assign rise    = wide_hi ? pin_rise[EVEN] : pin_rise[SELF];
      assign fall    = wide_hi ? pin_fall[EVEN] : pin_fall[SELF];
      assign run     = tcs_may_run(cfg, idle_in, sleep_in, 1'b0); // see RL10
      assign gate_on = cfg.gate_accumulate && !cfg.clock_source_select; // see RL5
      assign raw     = run && (cfg.clock_source_select ? rise : (!gate_on || lvl)); // see RL22
      assign tmr_gfall[j] = run && gate_on && fall;

      tcs_prescale u_ps (
        .clk_in   (core_clk_in),
        .rst_b_in (rst_b_q),
        .clr_in   (!run),
        .sel_in   (cfg.prescale_select),
        .tick_in  (raw),
        .tick_out (tmr_tick[j])
      );
    end

    for (p = 0; p < 4; p++) begin : g_pair
      assign pair_wide[p] = st_ff.ctrl[2 * p + 1][`TCS_BIT_WIDE]; // see RL15

      tcs_pair u_pair (
        .clk_in       (core_clk_in),
        .rst_b_in     (rst_b_q),
        .wide_in      (pair_wide[p]),
        .tick_in      (tmr_tick[2 * p + 1:2 * p]),
        .gate_fall_in (tmr_gfall[2 * p + 1:2 * p]),
        .period_in    ({st_ff.period[2 * p + 2], st_ff.period[2 * p + 1]}),
        .count_out    (pair_cnt[p]),
        .flag_out     (pair_flag_out[2 * p + 1:2 * p])
      );

      assign cnt_all[2 * p + 1] = pair_cnt[p][0];
      assign cnt_all[2 * p + 2] = pair_cnt[p][1];
    end
  endgenerate

  assign cnt_all[0] = st_ff.sa_count;

  // ==========================================================
  // Next state: registers, synchronisers, standalone count
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.rd_data = `TCS_RST_WORD;
    nxt_st.sa_flag = 1'b0;
    nxt_st.pin_s1  = {pair_ext_clock_pin_in, standalone_ext_clock_pin_in};
    nxt_st.pin_s2  = st_ff.pin_s1;
    nxt_st.pin_d   = st_ff.pin_s2;

    if (sa_tick) begin
      if (st_ff.sa_count == st_ff.period[0]) begin // see RL21
        nxt_st.sa_count = `TCS_RST_WORD;
        nxt_st.sa_flag  = 1'b1;
      end else begin
        nxt_st.sa_count = st_ff.sa_count + 16'h0001;
      end
    end
    if (sa_gate_fall) begin
      nxt_st.sa_flag = 1'b1; // see RL2
    end

    if (bus_in.wr) begin
      case (hit.kind)
        tcs_pkg::TCS_K_CTRL: nxt_st.ctrl[hit.idx]   = bus_in.wdata & tcs_wmask(hit.idx); // see RL9
        tcs_pkg::TCS_K_PER:  nxt_st.period[hit.idx] = bus_in.wdata;
        default:             nxt_st.rd_data         = `TCS_RST_WORD;
      endcase
    end
    if (bus_in.rd) begin
      case (hit.kind)
        tcs_pkg::TCS_K_CTRL: nxt_st.rd_data = st_ff.ctrl[hit.idx];
        tcs_pkg::TCS_K_PER:  nxt_st.rd_data = st_ff.period[hit.idx];
        tcs_pkg::TCS_K_CNT:  nxt_st.rd_data = cnt_all[hit.idx];
        default:             nxt_st.rd_data = `TCS_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_q) begin
    if (!rst_b_q) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Outputs and triggers
  assign rd_data_out         = st_ff.rd_data;
  assign standalone_flag_out = st_ff.sa_flag;
  assign adc_trig_out        = {pair_flag_out[3], pair_flag_out[1]}; // see RL16
  assign dma_trig_out        = pair_flag_out[1:0]; // see RL18
  assign capture_base_out    = pair_cnt[0]; // see RL17

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_q);

  sa_wrap_a: assert property ( // see RL21
    sa_tick && st_ff.sa_count == st_ff.period[0] |=> st_ff.sa_count == 16'h0000 && standalone_flag_out)
    else $error("standalone timer did not wrap at period");

  sa_step_a: assert property ( // see RL1
    sa_tick && st_ff.sa_count != st_ff.period[0] |=> st_ff.sa_count == $past(st_ff.sa_count) + 16'h0001)
    else $error("standalone timer did not step by one");

  sa_stop_a: assert property ( // see RL3
    !sa_cfg.run |=> $stable(st_ff.sa_count))
    else $error("stopped standalone timer changed");

  idle_halt_a: assert property ( // see RL4
    idle_in && sa_cfg.idle_stop |=> $stable(st_ff.sa_count))
    else $error("timer counted in idle with idle stop set");

  gate_hold_a: assert property ( // see RL22
    sa_gate_on && !st_ff.pin_s2[0] |=> $stable(st_ff.sa_count))
    else $error("gated timer advanced while gate low");

  gate_irq_a: assert property ( // see RL2
    sa_run && sa_gate_on && pin_fall[0] |=> standalone_flag_out)
    else $error("gate fall did not raise standalone flag");

  unimpl_zero_a: assert property ( // see RL9
    bus_in.rd && bus_in.addr == `TCS_ADDR_SA_CTRL |=> (rd_data_out & ~`TCS_MASK_SA) == 16'h0000)
    else $error("unimplemented control bits read nonzero");

  ps8_spacing_a: assert property ( // see RL6
    sa_tick && sa_cfg.prescale_select == 2'h1 && $stable(sa_cfg) |=> !sa_tick [*7])
    else $error("prescale by eight ticked too soon");

  wide_flag_a: assert property ( // see RL13
    $past(pair_wide[0]) |-> !pair_flag_out[0])
    else $error("even timer flagged in wide mode");

  adc_trig_a: assert property ( // see RL16
    pair_flag_out[3] |-> adc_trig_out[1] && !dma_trig_out[1] == !pair_flag_out[1])
    else $error("second ADC trigger missing");

  sleep_halt_a: assert property ( // see RL7
    sleep_in && !(sa_cfg.clock_source_select && !sa_cfg.ext_clock_sync) |=> $stable(st_ff.sa_count))
    else $error("synchronised standalone timer counted in sleep");

  pair_sleep_a: assert property ( // see RL10
    sleep_in |=> $stable(pair_cnt))
    else $error("paired timer counted in sleep");

  ext_edge_a: assert property ( // see RL8
    sa_cfg.clock_source_select && !pin_rise[0] |=> $stable(st_ff.sa_count))
    else $error("external timer counted without a pin edge");

  wide_step_a: assert property ( // see RL11
    pair_wide[0] && tmr_tick[0] && pair_cnt[0] != {st_ff.period[2], st_ff.period[1]}
    |=> pair_cnt[0] == $past(pair_cnt[0]) + 32'h0000_0001)
    else $error("wide count did not carry into upper word");

  wide_wrap_a: assert property ( // see RL14
    pair_wide[0] && tmr_tick[0] && pair_cnt[0] == {st_ff.period[2], st_ff.period[1]}
    |=> pair_cnt[0] == 32'h0000_0000 && pair_flag_out[1])
    else $error("wide count did not wrap at joined period");

  sa_wrap_c:  cover property (sa_tick && st_ff.sa_count == st_ff.period[0] && st_ff.period[0] != 16'h0000);
  gate_fall_c: cover property (sa_gate_fall);
  wide_wrap_c: cover property (pair_wide[0] ##1 pair_flag_out[1]);
  reg_read_c: cover property (bus_in.rd && hit.kind == tcs_pkg::TCS_K_CNT);

endmodule : tcs_timer_set

// >>> tb.sv
/*
  Self-checking bench of the timer set: register port, standalone timer,
  timer pairs in 16 and 32-bit mode, idle, sleep and trigger outputs.
  Assumes the design files and tcs_consts.svh are compiled before it.
*/
`timescale 1ns/10ps
`include "tcs_consts.svh"

module tb;
  logic              core_clk_in;
  logic              rst_b_in;
  tcs_pkg::tcs_bus_t bus;
  logic              idle;
  logic              sleep;
  logic              sa_pin;
  logic [7:0]        pair_pin;
  logic [15:0]       rd_data;
  logic              sa_flag;
  logic [7:0]        pair_flag;
  logic [1:0]        adc_trig;
  logic [1:0]        dma_trig;
  logic [1:0][15:0]  cap_base;
  wire  [8:0]        flg = {pair_flag, sa_flag};
  int                err_total;
  int                n_compared;
  int                seed = 32'h694b3f7c;
  int                n;
  int                p;
  logic [15:0]       v0;
  logic [15:0]       v1;
  logic              bad;

  tcs_timer_set i_tcs_timer_set (
    .core_clk_in                 (core_clk_in),
    .rst_b_in                    (rst_b_in),
    .bus_in                      (bus),
    .idle_in                     (idle),
    .sleep_in                    (sleep),
    .standalone_ext_clock_pin_in (sa_pin),
    .pair_ext_clock_pin_in       (pair_pin),
    .rd_data_out                 (rd_data),
    .standalone_flag_out         (sa_flag),
    .pair_flag_out               (pair_flag),
    .adc_trig_out                (adc_trig),
    .dma_trig_out                (dma_trig),
    .capture_base_out            (cap_base)
  );

  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end

  // ==========================================================
  // Helpers
  function automatic int exp_gap(input int per, input int ps);
    return (per + 1) << (ps == 3 ? 8 : 3 * ps);
  endfunction : exp_gap

  task summarize;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge core_clk_in);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk_in);
    bus.wr <= 1'b0;
  endtask : wr

  // Data stands only in the cycle after the strobe, so sample just past that edge
  task rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge core_clk_in);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge core_clk_in);
    bus.rd <= 1'b0;
    #1 d = rd_data;
  endtask : rd

  // Two reads w+2 cycles apart
  task delta(input logic [5:0] a, input int w, output logic [15:0] dd);
    rd(a, v0);
    repeat (w) @(posedge core_clk_in);
    rd(a, v1);
    dd = v1 - v0;
  endtask : delta

  task wait_flag(input int idx, output int g);
    g = 0;
    while (flg[idx] !== 1'b1) begin
      @(negedge core_clk_in);
      g++;
      if (g > 70000) begin
        err_total++;
        $display("ERROR wait for flag %0d timed out", idx);
        summarize();
      end
    end
  endtask : wait_flag

  task gap(input int idx, output int g);
    wait_flag(idx, g);
    @(negedge core_clk_in);
    wait_flag(idx, g);
    g++;
  endtask : gap

  // Pin widths vary so the edge detector sees uneven pulses
  task edges(input int k, input int idx);
    repeat (k) begin
      repeat (2 + ($random(seed) & 3)) @(posedge core_clk_in);
      {pair_pin, sa_pin} <= 9'h001 << idx;
      repeat (2 + ($random(seed) & 3)) @(posedge core_clk_in);
      {pair_pin, sa_pin} <= 9'h000;
    end
    repeat (6) @(posedge core_clk_in);
  endtask : edges

  // ==========================================================
  // Main sequence
  initial begin
    rst_b_in   = 1'b0;
    bus        = '0;
    idle       = 1'b0;
    sleep      = 1'b0;
    sa_pin     = 1'b0;
    pair_pin   = 8'h00;
    err_total  = 0;
    n_compared = 0;
    repeat (16) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    for (int a = 0; a < 3; a++) begin
      rd(6'(a), v0);
      check("reset value", v0, 16'h0000);
    end
    wr(`TCS_ADDR_SA_CTRL, 16'hFFFF);
    wr(6'h08, 16'hFFFF);
    wr(6'h09, 16'hFFFF);
    rd(`TCS_ADDR_SA_CTRL, v0);
    check("standalone control mask", v0, `TCS_MASK_SA);
    rd(6'h08, v0);
    check("even control mask", v0, `TCS_MASK_EVEN);
    rd(6'h09, v0);
    check("odd control mask", v0, `TCS_MASK_ODD);
    wr(`TCS_ADDR_SA_CTRL, 16'h0000);
    wr(6'h08, 16'h0000);
    wr(6'h09, 16'h0000);
    wr(6'h07, 16'h1234);
    rd(6'h07, v0);
    check("unmapped read", v0, 16'h0000);
    wr(`TCS_ADDR_SA_CNT, 16'h1234);
    rd(`TCS_ADDR_SA_CNT, v0);
    check("count write ignored", v0, 16'h0000);
    for (int ps = 0; ps < 4; ps++) begin
      p = ($random(seed) & 7) + 1;
      wr(`TCS_ADDR_SA_PER, 16'(p));
      wr(`TCS_ADDR_SA_CTRL, 16'h8000 | 16'(ps << 4));
      gap(0, n);
      check("standalone flag gap", n, exp_gap(p, ps));
      wr(`TCS_ADDR_SA_CTRL, 16'h0000);
    end
    wr(`TCS_ADDR_SA_PER, 16'hFFFF);
    wr(`TCS_ADDR_SA_CTRL, 16'h8000);
    delta(`TCS_ADDR_SA_CNT, 10, v0);
    check("running count", v0, 12);
    wr(`TCS_ADDR_SA_CTRL, 16'hA000);
    idle <= 1'b1;
    delta(`TCS_ADDR_SA_CNT, 10, v0);
    check("idle halted count", v0, 0);
    wr(`TCS_ADDR_SA_CTRL, 16'h8000);
    delta(`TCS_ADDR_SA_CNT, 10, v0);
    check("idle running count", v0, 12);
    wr(`TCS_ADDR_SA_CTRL, 16'h0000);
    idle <= 1'b0;
    delta(`TCS_ADDR_SA_CNT, 10, v0);
    check("stopped count", v0, 0);
    wr(`TCS_ADDR_SA_CTRL, 16'h8040);
    rd(`TCS_ADDR_SA_CNT, v0);
    @(posedge core_clk_in);
    sa_pin <= 1'b1;
    repeat (20) @(posedge core_clk_in);
    sa_pin <= 1'b0;
    wait_flag(0, n);
    check("gate fall flag delay", n < 8, 1);
    rd(`TCS_ADDR_SA_CNT, v1);
    check("gated count", v1 - v0, 20);
    wr(`TCS_ADDR_SA_CTRL, 16'h8046);
    rd(`TCS_ADDR_SA_CNT, v0);
    edges(10, 0);
    rd(`TCS_ADDR_SA_CNT, v1);
    check("pin edge count", v1 - v0, 10);
    sleep <= 1'b1;
    rd(`TCS_ADDR_SA_CNT, v0);
    edges(5, 0);
    rd(`TCS_ADDR_SA_CNT, v1);
    check("synced count in sleep", v1 - v0, 0);
    wr(`TCS_ADDR_SA_CTRL, 16'h8042);
    rd(`TCS_ADDR_SA_CNT, v0);
    edges(5, 0);
    rd(`TCS_ADDR_SA_CNT, v1);
    check("async count in sleep", v1 - v0, 5);
    sleep <= 1'b0;
    wr(`TCS_ADDR_SA_CTRL, 16'h0000);
    wr(6'h22, 16'hFFFF);
    wr(6'h20, 16'h8002);
    rd(6'h24, v0);
    edges(6, 7);
    rd(6'h24, v1);
    check("pair pin edge count", v1 - v0, 6);
    wr(6'h20, 16'h0000);
    wr(6'h0A, 16'h0005);
    wr(6'h0B, 16'h0003);
    wr(6'h08, 16'h8000);
    wr(6'h09, 16'h8000);
    gap(1, n);
    check("even timer gap", n, 6);
    gap(2, n);
    check("odd timer gap", n, 4);
    // Odd timer stops on its wrap, so the joined count starts with a zero upper word
    wr(6'h08, 16'h0000);
    wr(6'h09, 16'h0000);
    rd(6'h0C, v0);
    check("capture base even", cap_base[0], v0);
    rd(6'h0D, v0);
    check("capture base odd", cap_base[1], v0);
    wr(6'h0B, 16'h0000);
    wr(6'h09, 16'hA030);
    wr(6'h13, 16'h0002);
    wr(6'h11, 16'h8000);
    wr(6'h08, 16'h8008);
    gap(2, n);
    check("wide flag gap", n, 6);
    bad = 1'b0;
    n   = 0;
    p   = 0;
    repeat (42) begin
      @(negedge core_clk_in);
      bad = bad | flg[1] | (adc_trig !== {pair_flag[3], pair_flag[1]}) | (dma_trig !== pair_flag[1:0]);
      n += adc_trig[1];
      p += adc_trig[0];
    end
    check("even flag or triggers", bad, 0);
    check("second ADC trigger pulses", n, 14);
    check("first ADC trigger pulses", p, 7);
    check("dma trigger source", dma_trig === pair_flag[1:0], 1);
    wr(6'h11, 16'h0000);
    wr(6'h08, 16'h0000);
    wr(6'h0B, 16'h0001);
    wr(6'h08, 16'h8008);
    wait_flag(2, n);
    check("wide period span", n > 65530 && n < 65546, 1);
    summarize();
  end
endmodule : tb
